// File: src/sfr_guard_pkg.sv
// Package of constants and types for the register privilege checker.
package sfr_guard_pkg;

	// ==========================================================
	// Privilege modes, Gray coded along user, system, super.
	typedef enum logic [1:0] {
		USER_MODE         = 2'b00,
		SYSTEM_MODE       = 2'b01,
		SUPER_SYSTEM_MODE = 2'b11
	} priv_mode_e;

	// Register groups, taken from address bits [7:6].
	typedef enum logic [1:0] {
		SYSTEM_MANAGEMENT_GROUP = 2'b00,
		SEGMENT_CONFIG_GROUP    = 2'b01,
		TEST_GROUP              = 2'b10,
		HW_COMPONENT_GROUP      = 2'b11
	} reg_group_e;

	// Mode change events issued by the core.
	typedef enum logic [2:0] {
		EV_NONE          = 3'h0,
		EV_ENTER_USER    = 3'h1,
		EV_ENTER_SYSTEM  = 3'h2,
		EV_ENTER_SUPER   = 3'h3,
		EV_INTERRUPT     = 3'h4,
		EV_RETURN_IRQ    = 3'h5
	} mode_event_e;

	// Core side register access request.
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} core_req_s;

	// ==========================================================
	// Layout of the 256-entry register space.
	localparam int          GROUP_MSB        = 7;
	localparam int          GROUP_LSB        = 6;
	localparam logic [7:0]  USER_EVAL_ADDR   = 8'h00;
	localparam logic [7:0]  WATCHDOG_ADDR    = 8'h01;
	localparam logic [7:0]  SCRATCH_BASE_ADDR = 8'h02;
	localparam logic [7:0]  POLICY_ADDR      = 8'h03;
	localparam logic [7:0]  FEATURE_TMP_ADDR = 8'h04;
	localparam logic [7:0]  FEATURE_PERM_ADDR = 8'h05;
	localparam logic [7:0]  SCRATCH_SEG_ADDR = 8'h40;
	localparam logic [7:0]  CHECKSUM_HI_ADDR = 8'hc0;
	localparam logic [7:0]  CHECKSUM_LO_ADDR = 8'hc1;
	localparam logic [7:0]  KEY_FIRST_ADDR   = 8'hd0;
	localparam logic [7:0]  KEY_LAST_ADDR    = 8'hdf;
	// Policy bit: when set, user mode loses its exception registers.
	localparam int          POLICY_USER_LOCK_BIT = 0;
	localparam logic [7:0]  RESET_VALUE      = 8'h00;
	localparam logic [5:0]  FEATURE_RESET    = 6'h3f;
	localparam int          FEATURE_COUNT    = 6;

	// ==========================================================
	// APB map of the checker's own registers (byte addresses).
	localparam logic [11:0] APB_MODE_OFF     = 12'h000;
	localparam logic [11:0] APB_STATUS_OFF   = 12'h004;
	localparam logic [11:0] APB_MASK_OFF     = 12'h008;
	localparam logic [11:0] APB_FEATURE_OFF  = 12'h00c;
	localparam logic [11:0] APB_VIOL_ADDR_OFF = 12'h010;
	localparam int          STATUS_READ_DENY  = 0;
	localparam int          STATUS_WRITE_DENY = 1;
	localparam int          STATUS_MODE_CHG   = 2;
	localparam logic [2:0]  MASK_RESET        = 3'h0;

endpackage

// File: src/sfr_privilege_access_control.sv
// Privilege checker and register file for core special register access.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
// Behaviour
// R1: super mode reaches all four groups.
// R2: system mode reaches all but test group.
// R3: user mode reaches segment and hw groups.
// R4: user may use three system-management exceptions.
// R5: policy config can block user exception registers.
// R6: user cannot read checksum or key registers.
// R7: segment group registers reset to zero.
// R8: security registers have fixed restrictive resets.
// R9: segment writes need system mode, scratch excepted.
// R10: attributes change only via permitted writes.
// R11: mode instructions select user, system, super.
// R12: interrupts and return change mode; checks follow.
// R13: features enabled or disabled temporarily, permanently.
// R14: denied access hides data, flags a violation.
module sfr_privilege_access_control (
	input  wire logic                      clk,
	input  wire logic                      resetn,
	input  wire logic                      clk_en,
	input  wire sfr_guard_pkg::core_req_s  core_req,
	input  wire sfr_guard_pkg::mode_event_e mode_event,
	input  wire logic                      irq_to_super,
	output logic [7:0]                     core_rdata,
	output logic                           core_rvalid,
	output logic                           core_violation,
	output sfr_guard_pkg::priv_mode_e      cur_mode,
	output logic [5:0]                     feature_enable,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr,
	output logic                           irq
);

	// ==========================================================
	// State.
	sfr_guard_pkg::priv_mode_e mode_reg;
	sfr_guard_pkg::priv_mode_e saved_mode_reg;
	logic [7:0]  regs_reg [256];
	logic [5:0]  feat_tmp_reg;
	logic [5:0]  feat_perm_reg;
	logic [2:0]  status_reg;
	logic [2:0]  mask_reg;
	logic [7:0]  viol_addr_reg;
	logic        grant;
	logic        user_exc;
	logic        in_key;
	logic        is_scratch;
	logic        deny_rd;
	logic        deny_wr;
	logic        mode_chg;
	logic        apb_rd;
	logic        apb_acc;
	logic        status_clr;
	sfr_guard_pkg::reg_group_e grp;

	assign grp = sfr_guard_pkg::reg_group_e'(
		core_req.addr[sfr_guard_pkg::GROUP_MSB:sfr_guard_pkg::GROUP_LSB]);
	assign in_key = core_req.addr >= sfr_guard_pkg::KEY_FIRST_ADDR &&
		core_req.addr <= sfr_guard_pkg::KEY_LAST_ADDR;
	assign is_scratch = core_req.addr == sfr_guard_pkg::SCRATCH_SEG_ADDR;
	assign apb_acc = psel && penable;
	assign apb_rd = apb_acc && !pwrite;
	assign status_clr = apb_rd && paddr == sfr_guard_pkg::APB_STATUS_OFF;
	assign mode_chg = mode_event != sfr_guard_pkg::EV_NONE;

	// ==========================================================
	// Access decision. The lock bit only removes rights, never adds.
	always_comb begin
		user_exc = (core_req.addr == sfr_guard_pkg::USER_EVAL_ADDR ||
			core_req.addr == sfr_guard_pkg::WATCHDOG_ADDR ||
			core_req.addr == sfr_guard_pkg::SCRATCH_BASE_ADDR) && // R4
			!regs_reg[sfr_guard_pkg::POLICY_ADDR]
			[sfr_guard_pkg::POLICY_USER_LOCK_BIT]; // R5
		case (mode_reg)
			sfr_guard_pkg::SUPER_SYSTEM_MODE: grant = 1'b1; // R1
			sfr_guard_pkg::SYSTEM_MODE:
				grant = grp != sfr_guard_pkg::TEST_GROUP; // R2
			default: begin
				if (grp == sfr_guard_pkg::SEGMENT_CONFIG_GROUP) begin
					grant = !core_req.write || is_scratch; // R3 R9
				end else if (grp == sfr_guard_pkg::HW_COMPONENT_GROUP) begin
					grant = core_req.write || !(in_key || // R6
						core_req.addr == sfr_guard_pkg::CHECKSUM_HI_ADDR ||
						core_req.addr == sfr_guard_pkg::CHECKSUM_LO_ADDR);
				end else if (grp == sfr_guard_pkg::SYSTEM_MANAGEMENT_GROUP) begin
					grant = user_exc; // R3
				end else begin
					grant = 1'b0;
				end
			end
		endcase
		deny_rd = core_req.valid && !core_req.write && !grant;
		deny_wr = core_req.valid && core_req.write && !grant;
	end

	// ==========================================================
	// Mode tracking; the interrupt saves the mode for the return.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_reg <= sfr_guard_pkg::SUPER_SYSTEM_MODE;
			saved_mode_reg <= sfr_guard_pkg::SUPER_SYSTEM_MODE;
		end else if (clk_en) begin
			case (mode_event)
				sfr_guard_pkg::EV_ENTER_USER:
					mode_reg <= sfr_guard_pkg::USER_MODE; // R11
				sfr_guard_pkg::EV_ENTER_SYSTEM:
					mode_reg <= sfr_guard_pkg::SYSTEM_MODE; // R11
				sfr_guard_pkg::EV_ENTER_SUPER:
					mode_reg <= sfr_guard_pkg::SUPER_SYSTEM_MODE; // R11
				sfr_guard_pkg::EV_INTERRUPT: begin
					saved_mode_reg <= mode_reg; // R12
					mode_reg <= irq_to_super ?
						sfr_guard_pkg::SUPER_SYSTEM_MODE :
						sfr_guard_pkg::SYSTEM_MODE;
				end
				sfr_guard_pkg::EV_RETURN_IRQ:
					mode_reg <= saved_mode_reg; // R12
				default: mode_reg <= mode_reg;
			endcase
		end
	end

	// ==========================================================
	// Register array; fixed zero reset, no way to preload it.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 256; i++) begin
				regs_reg[i] <= sfr_guard_pkg::RESET_VALUE; // R7 R8
			end
		end else if (clk_en && core_req.valid && core_req.write && grant) begin
			regs_reg[core_req.addr] <= core_req.wdata; // R10 R14
		end
	end

	// Core read data; a denied read returns zero, not the content.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			core_rdata <= 8'h00;
			core_rvalid <= 1'b0;
			core_violation <= 1'b0;
		end else if (clk_en) begin
			core_rvalid <= core_req.valid && !core_req.write;
			core_rdata <= (core_req.valid && !core_req.write && grant) ?
				regs_reg[core_req.addr] : 8'h00; // R14
			core_violation <= deny_rd || deny_wr; // R14
		end
	end

	// ==========================================================
	// Features: temporary bits follow the register, permanent
	// disables are sticky until reset, so a later write cannot undo.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			feat_tmp_reg <= sfr_guard_pkg::FEATURE_RESET;
			feat_perm_reg <= sfr_guard_pkg::FEATURE_RESET;
		end else if (clk_en && core_req.valid && core_req.write && grant) begin
			if (core_req.addr == sfr_guard_pkg::FEATURE_TMP_ADDR) begin
				feat_tmp_reg <= core_req.wdata[5:0]; // R13
			end else if (core_req.addr == sfr_guard_pkg::FEATURE_PERM_ADDR) begin
				feat_perm_reg <= feat_perm_reg & core_req.wdata[5:0]; // R13
			end
		end
	end

	// Feature outputs per feature.
	for (genvar f = 0; f < sfr_guard_pkg::FEATURE_COUNT; f++) begin : g_feat
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				feature_enable[f] <= 1'b0;
			end else if (clk_en) begin
				feature_enable[f] <= feat_tmp_reg[f] && feat_perm_reg[f]; // R13
			end
		end
	end

	// Registered mode output.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cur_mode <= sfr_guard_pkg::SUPER_SYSTEM_MODE;
		end else if (clk_en) begin
			cur_mode <= mode_reg;
		end
	end

	// ==========================================================
	// Sticky status; set wins over the clear-on-read.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_reg <= 3'h0;
			viol_addr_reg <= 8'h00;
		end else if (clk_en) begin
			// A read clears only the bits it reported in its setup cycle,
			// so an event landing between setup and access is kept.
			status_reg <= (status_reg &
				~(status_clr ? prdata[2:0] : 3'h0)) |
				{mode_chg, deny_wr, deny_rd};
			if (deny_rd || deny_wr) begin
				viol_addr_reg <= core_req.addr;
			end
		end
	end

	// APB slave: zero wait states, unmapped address gives pslverr.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mask_reg <= sfr_guard_pkg::MASK_RESET;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && !penable) begin
				if (paddr == sfr_guard_pkg::APB_MODE_OFF) begin
					prdata <= {30'h0, mode_reg};
				end else if (paddr == sfr_guard_pkg::APB_STATUS_OFF) begin
					prdata <= {29'h0, status_reg};
				end else if (paddr == sfr_guard_pkg::APB_MASK_OFF) begin
					prdata <= {29'h0, mask_reg};
				end else if (paddr == sfr_guard_pkg::APB_FEATURE_OFF) begin
					prdata <= {26'h0, feat_tmp_reg & feat_perm_reg};
				end else if (paddr == sfr_guard_pkg::APB_VIOL_ADDR_OFF) begin
					prdata <= {24'h0, viol_addr_reg};
				end else begin
					pslverr <= 1'b1;
				end
			end
			if (apb_acc && pwrite && paddr == sfr_guard_pkg::APB_MASK_OFF) begin
				mask_reg <= pwdata[2:0];
			end
		end
	end

	// Interrupt output from a flop.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(status_reg & mask_reg);
		end
	end

	// ==========================================================
	// Checks. Each one watches what the logic above drives.
	a_test_denied: assert property ( // R2
		@(posedge clk) disable iff (!resetn)
		clk_en && core_req.valid && mode_reg == sfr_guard_pkg::SYSTEM_MODE &&
		grp == sfr_guard_pkg::TEST_GROUP |=> core_violation)
		else $error("System mode reached the test group.");
	a_super_all: assert property ( // R1
		@(posedge clk) disable iff (!resetn)
		clk_en && core_req.valid &&
		mode_reg == sfr_guard_pkg::SUPER_SYSTEM_MODE |=> !core_violation)
		else $error("Super mode access was refused.");
	a_user_key_read: assert property ( // R6
		@(posedge clk) disable iff (!resetn)
		clk_en && core_req.valid && !core_req.write && in_key &&
		mode_reg == sfr_guard_pkg::USER_MODE |=> core_rdata == 8'h00)
		else $error("User mode read key material.");
	a_user_sysmgmt: assert property ( // R3
		@(posedge clk) disable iff (!resetn)
		clk_en && core_req.valid && mode_reg == sfr_guard_pkg::USER_MODE &&
		grp == sfr_guard_pkg::SYSTEM_MANAGEMENT_GROUP && !user_exc
		|=> core_violation)
		else $error("User mode reached a system register.");
	a_user_exc: assert property ( // R4
		@(posedge clk) disable iff (!resetn)
		clk_en && core_req.valid && mode_reg == sfr_guard_pkg::USER_MODE &&
		core_req.addr == sfr_guard_pkg::WATCHDOG_ADDR &&
		!regs_reg[sfr_guard_pkg::POLICY_ADDR]
		[sfr_guard_pkg::POLICY_USER_LOCK_BIT] |=> !core_violation)
		else $error("User watchdog access was refused.");
	a_seg_write: assert property ( // R9
		@(posedge clk) disable iff (!resetn)
		clk_en && core_req.valid && core_req.write && !is_scratch &&
		mode_reg == sfr_guard_pkg::USER_MODE &&
		grp == sfr_guard_pkg::SEGMENT_CONFIG_GROUP
		|=> regs_reg[$past(core_req.addr)] ==
		$past(regs_reg[core_req.addr]))
		else $error("User mode changed a segment register.");
	a_enter_user: assert property ( // R11
		@(posedge clk) disable iff (!resetn)
		clk_en && mode_event == sfr_guard_pkg::EV_ENTER_USER
		|=> mode_reg == sfr_guard_pkg::USER_MODE ##1 cur_mode == mode_reg)
		else $error("Mode did not switch to user.");
	a_irq_return: assert property ( // R12
		@(posedge clk) disable iff (!resetn)
		clk_en && mode_event == sfr_guard_pkg::EV_INTERRUPT ##1
		clk_en && mode_event == sfr_guard_pkg::EV_RETURN_IRQ
		|=> mode_reg == $past(mode_reg, 2))
		else $error("Return did not restore the mode.");
	a_perm_sticky: assert property ( // R13
		@(posedge clk) disable iff (!resetn)
		clk_en |=> (feat_perm_reg & ~$past(feat_perm_reg)) == 6'h00)
		else $error("Permanent disable was undone.");
	a_deny_hides: assert property ( // R14
		@(posedge clk) disable iff (!resetn)
		clk_en && deny_rd |=> core_violation && core_rdata == 8'h00)
		else $error("A denied read showed register content.");

endmodule

// File: verif/core_model.sv
// Behavioural processor core that issues register accesses and mode events.
`timescale 1ns/1ps
module core_model (
	input  wire logic                  clk,
	output sfr_guard_pkg::core_req_s   core_req,
	output sfr_guard_pkg::mode_event_e mode_event,
	output logic                       irq_to_super
);
	// Idle cycles before each access, so the core can be prompt or slow.
	int pace = 0;

	// ==========================================================
	// Idle values at time zero.
	initial begin
		core_req = '0;
		mode_event = sfr_guard_pkg::EV_NONE;
		irq_to_super = 1'b0;
	end

	// One access held for one taking edge; released fields show the inverse,
	// so a design that samples stale fields cannot match by luck.
	task automatic access(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		repeat (pace) @(posedge clk);
		@(posedge clk);
		core_req <= '{1'b1, w, a, d};
		@(posedge clk);
		core_req <= '{1'b0, ~w, ~a, ~d};
	endtask

	// One mode event pulse, with the handler mode choice beside it.
	task automatic mode_pulse(input sfr_guard_pkg::mode_event_e e,
		input logic sup);
		@(posedge clk);
		mode_event <= e;
		irq_to_super <= sup;
		@(posedge clk);
		mode_event <= sfr_guard_pkg::EV_NONE;
		irq_to_super <= ~sup;
	endtask

	// Two events on consecutive edges, as when a handler returns at once.
	task automatic mode_pair(input sfr_guard_pkg::mode_event_e e1,
		input sfr_guard_pkg::mode_event_e e2);
		@(posedge clk);
		mode_event <= e1;
		@(posedge clk);
		mode_event <= e2;
		@(posedge clk);
		mode_event <= sfr_guard_pkg::EV_NONE;
	endtask
endmodule

// File: verif/test_sfr_privilege_access_control.sv
// Self-checking testbench for the register privilege checker.
`timescale 1ns/1ps
module test_sfr_privilege_access_control;
	logic                       clk, resetn, clk_en, irq, irq_to_super;
	logic                       psel, penable, pwrite, pready, pslverr;
	logic                       core_rvalid, core_violation, er;
	logic [11:0]                paddr;
	logic [31:0]                pwdata, prdata, rd;
	logic [7:0]                 core_rdata;
	logic [5:0]                 feature_enable;
	logic [7:0]                 shadow [256];
	sfr_guard_pkg::core_req_s   core_req;
	sfr_guard_pkg::mode_event_e mode_event;
	sfr_guard_pkg::priv_mode_e  cur_mode;
	int                         err_total, n_checks, cycles;

	sfr_privilege_access_control dut_u (.clk(clk), .resetn(resetn),
		.clk_en(clk_en), .core_req(core_req), .mode_event(mode_event),
		.irq_to_super(irq_to_super), .core_rdata(core_rdata),
		.core_rvalid(core_rvalid), .core_violation(core_violation),
		.cur_mode(cur_mode), .feature_enable(feature_enable), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	core_model core_u (.clk(clk), .core_req(core_req),
		.mode_event(mode_event), .irq_to_super(irq_to_super));

	// ==========================================================
	// Clock and a watchdog that ends a hung run as a failure.
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; holds the request until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Core access with expected outcome; shadow holds permitted writes only.
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic deny);
		core_u.access(w, a, d);
		#1;
		chk(core_violation, deny);
		if (!w) chk(core_rdata, deny ? 8'h00 : shadow[a]);
		chk(core_rvalid, !w);
		if (w && !deny) shadow[a] = d;
	endtask

	task automatic mode(input sfr_guard_pkg::mode_event_e e,
		input logic sup, input sfr_guard_pkg::priv_mode_e m);
		core_u.mode_pulse(e, sup);
		settle(2);
		chk(cur_mode, m);
	endtask

	task automatic feat(input logic [7:0] a, input logic [7:0] d,
		input logic deny, input logic [5:0] exp);
		acc(1'b1, a, d, deny);
		settle(2);
		chk(feature_enable, exp);
	endtask

	// ==========================================================
	// Main sequence.
	initial begin
		clk = 0; resetn = 0; clk_en = 1; cycles = 0;
		psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
		err_total = 0; n_checks = 0;
		foreach (shadow[i]) shadow[i] = 8'h00;
		repeat (8) @(posedge clk);
		chk(cur_mode, sfr_guard_pkg::SUPER_SYSTEM_MODE);
		chk(irq, 1'b0);
		resetn <= 1'b1;
		settle(2);
		chk(feature_enable, 6'h3f);
		apb(0, sfr_guard_pkg::APB_MASK_OFF, 0);
		chk(rd, 32'h0);
		apb(0, 12'h020, 0);
		chk(er, 1'b1);
		for (int a = 8'h40; a < 8'h80; a++) acc(0, a[7:0], 0, 0);
		// Super mode reaches every group; slow core pacing on the way.
		core_u.pace = 2;
		for (int g = 0; g < 4; g++) begin
			acc(1, {g[1:0], 6'h08}, 8'ha5 + g[7:0], 0);
			acc(0, {g[1:0], 6'h08}, 0, 0);
		end
		core_u.pace = 0;
		mode(sfr_guard_pkg::EV_ENTER_SYSTEM, 0, sfr_guard_pkg::SYSTEM_MODE);
		for (int g = 0; g < 4; g++) acc(0, {g[1:0], 6'h08}, 0, g == 2);
		acc(1, 8'h88, 8'h5a, 1);
		mode(sfr_guard_pkg::EV_ENTER_USER, 0, sfr_guard_pkg::USER_MODE);
		acc(0, 8'h48, 0, 0);
		acc(1, 8'h40, 8'h3c, 0);
		acc(0, 8'h40, 0, 0);
		acc(1, 8'h41, 8'h77, 1);
		acc(0, 8'h41, 0, 0);
		acc(1, 8'hc0, 8'h12, 0);
		acc(0, 8'hc0, 0, 1);
		acc(0, 8'hc1, 0, 1);
		acc(1, 8'hd5, 8'h99, 0);
		acc(0, 8'hd5, 0, 1);
		acc(0, 8'hc3, 0, 0);
		for (int a = 0; a < 3; a++) begin
			acc(1, a[7:0], 8'h11 + a[7:0], 0);
			acc(0, a[7:0], 0, 0);
		end
		acc(0, 8'h03, 0, 1);
		acc(0, 8'h08, 0, 1);
		acc(0, 8'h88, 0, 1);
		// Interrupt entry and return move the checking context.
		mode(sfr_guard_pkg::EV_INTERRUPT, 0, sfr_guard_pkg::SYSTEM_MODE);
		acc(0, 8'h08, 0, 0);
		mode(sfr_guard_pkg::EV_RETURN_IRQ, 0, sfr_guard_pkg::USER_MODE);
		acc(0, 8'h08, 0, 1);
		mode(sfr_guard_pkg::EV_INTERRUPT, 1,
			sfr_guard_pkg::SUPER_SYSTEM_MODE);
		acc(0, 8'h88, 0, 0);
		mode(sfr_guard_pkg::EV_RETURN_IRQ, 0, sfr_guard_pkg::USER_MODE);
		// Interrupt and return on consecutive edges restore user mode.
		core_u.mode_pair(sfr_guard_pkg::EV_INTERRUPT,
			sfr_guard_pkg::EV_RETURN_IRQ);
		settle(2);
		chk(cur_mode, sfr_guard_pkg::USER_MODE);
		feat(sfr_guard_pkg::FEATURE_TMP_ADDR, 8'h00, 1, 6'h3f);
		// Policy lock takes the exception registers away from user mode.
		mode(sfr_guard_pkg::EV_ENTER_SUPER, 0,
			sfr_guard_pkg::SUPER_SYSTEM_MODE);
		acc(1, sfr_guard_pkg::POLICY_ADDR, 8'h01, 0);
		mode(sfr_guard_pkg::EV_ENTER_USER, 0, sfr_guard_pkg::USER_MODE);
		acc(0, 8'h00, 0, 1);
		acc(1, 8'h01, 8'h33, 1);
		acc(0, 8'h01, 0, 1);
		acc(0, 8'h40, 0, 0);
		mode(sfr_guard_pkg::EV_ENTER_SUPER, 0,
			sfr_guard_pkg::SUPER_SYSTEM_MODE);
		acc(1, sfr_guard_pkg::POLICY_ADDR, 8'h00, 0);
		// A low clock enable freezes the mode across an event.
		@(posedge clk);
		clk_en <= 1'b0;
		core_u.mode_pulse(sfr_guard_pkg::EV_ENTER_USER, 0);
		@(posedge clk);
		clk_en <= 1'b1;
		settle(2);
		chk(cur_mode, sfr_guard_pkg::SUPER_SYSTEM_MODE);
		// Temporary bits come back; permanent ones only by reset.
		feat(sfr_guard_pkg::FEATURE_TMP_ADDR, 8'h3c, 0, 6'h3c);
		feat(sfr_guard_pkg::FEATURE_PERM_ADDR, 8'h2f, 0, 6'h2c);
		feat(sfr_guard_pkg::FEATURE_TMP_ADDR, 8'h3f, 0, 6'h2f);
		feat(sfr_guard_pkg::FEATURE_PERM_ADDR, 8'h3f, 0, 6'h2f);
		apb(0, sfr_guard_pkg::APB_FEATURE_OFF, 0);
		chk(rd, 32'h2f);
		// Violation status, mask and interrupt level.
		apb(1, sfr_guard_pkg::APB_MASK_OFF, 32'h1);
		mode(sfr_guard_pkg::EV_ENTER_USER, 0, sfr_guard_pkg::USER_MODE);
		apb(0, sfr_guard_pkg::APB_STATUS_OFF, 0);
		acc(0, 8'h80, 0, 1);
		settle(3);
		chk(irq, 1'b1);
		apb(0, sfr_guard_pkg::APB_VIOL_ADDR_OFF, 0);
		chk(rd, 32'h80);
		apb(0, sfr_guard_pkg::APB_STATUS_OFF, 0);
		chk(rd, 32'h1);
		settle(3);
		chk(irq, 1'b0);
		acc(1, 8'h81, 8'h44, 1);
		settle(3);
		chk(irq, 1'b0);
		apb(0, sfr_guard_pkg::APB_STATUS_OFF, 0);
		chk(rd, 32'h2);
		apb(1, sfr_guard_pkg::APB_MASK_OFF, 32'h4);
		apb(0, sfr_guard_pkg::APB_MASK_OFF, 0);
		chk(rd, 32'h4);
		mode(sfr_guard_pkg::EV_INTERRUPT, 1,
			sfr_guard_pkg::SUPER_SYSTEM_MODE);
		settle(2);
		chk(irq, 1'b1);
		apb(0, sfr_guard_pkg::APB_STATUS_OFF, 0);
		chk(rd, 32'h4);
		apb(0, sfr_guard_pkg::APB_MODE_OFF, 0);
		chk(rd, 32'h3);
		complete_run();
	end
endmodule
